// *** design/homing_pkg.sv ***
// Register map, codes and timing constants for the homing sequencer
package homing_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_TRIGGER = 5'h00;
    localparam logic [4:0] OFS_METHOD = 5'h04;
    localparam logic [4:0] OFS_OFFSET = 5'h08;
    localparam logic [4:0] OFS_OFFSET_SEL = 5'h0C;
    localparam logic [4:0] OFS_TIME_LIMIT = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    // Reset values
    localparam logic [3:0] RST_TRIGGER = 4'h0;
    localparam logic [5:0] RST_METHOD = 6'h00;
    localparam logic [15:0] RST_TIME_LIMIT = 16'h2710;
    // Trigger codes
    localparam logic [3:0] TRIG_IMMEDIATE = 4'h4;
    localparam logic [3:0] TRIG_CURRENT = 4'h6;
    // Method codes
    localparam logic [5:0] METH_HOME_FWD = 6'h00;
    localparam logic [5:0] METH_HOME_REV = 6'h01;
    localparam logic [5:0] METH_INDEX_FWD = 6'h02;
    localparam logic [5:0] METH_INDEX_REV = 6'h03;
    localparam logic [5:0] METH_HOME_INDEX = 6'h04;
    localparam logic [5:0] METH_MAX = 6'h22;
    // Status bit positions
    localparam int STS_ACTIVE = 0;
    localparam int STS_DONE = 1;
    localparam int STS_FAULT = 2;
    localparam int STS_BAD_METHOD = 3;
    localparam int STS_STATE_LSB = 4;
    // Sensor bit positions
    localparam int SNS_HOME = 0;
    localparam int SNS_POS = 1;
    localparam int SNS_NEG = 2;
    localparam int SNS_INDEX = 3;
    localparam int SNS_N = 4;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_APPROACH = 3'b001,
        ST_BACK = 3'b010,
        ST_RETURN = 3'b011,
        ST_CREEP = 3'b100,
        ST_OFFSET = 3'b101
    } seq_state_t;
endpackage

// *** design/sense_if.sv ***
// Synchronised sensor levels and edges
`timescale 1ns/1ps
interface sense_if;
    import homing_pkg::*;
    logic [SNS_N-1:0] level;
    logic [SNS_N-1:0] rise;
    logic [SNS_N-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// *** design/sensor_sync.sv ***
// Synchroniser and edge detector for switch and index inputs
`timescale 1ns/1ps
module sensor_sync
    import homing_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SNS_N-1:0] raw,
    sense_if.src sense
);
    logic [SNS_N-1:0] meta;
    logic [SNS_N-1:0] stable;
    logic [SNS_N-1:0] prior;

    // Two flops to settle, a third for edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta <= '0;
            stable <= '0;
            prior <= '0;
        end else begin
            meta <= raw;
            stable <= meta;
            prior <= stable;
        end
    end

    // Edges from consecutive samples
    assign sense.level = stable;
    assign sense.rise = stable & ~prior; // RULE21
    assign sense.fall = ~stable & prior; // RULE21
endmodule

// *** design/homing_timer.sv ***
// Millisecond timer that flags a homing run over its limit
`timescale 1ns/1ps
module homing_timer #(
    parameter int TICK_CYCLES = 50000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [15:0] limit_ms,
    output logic expired
);
    localparam int TW = $clog2(TICK_CYCLES);
    logic [TW-1:0] tick_cnt;
    logic [15:0] ms_cnt;
    wire tick_wrap = (tick_cnt == TW'(TICK_CYCLES - 1));

    // Count whole milliseconds while running; zero limit never expires
    always_ff @(posedge clk) begin
        if (!rst_b || !run) begin
            tick_cnt <= '0;
            ms_cnt <= 16'h0000;
            expired <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
            if (tick_wrap && ms_cnt != 16'hFFFF) begin
                ms_cnt <= ms_cnt + 16'h0001;
            end
            expired <= (limit_ms != 16'h0000) && (ms_cnt >= limit_ms); // RULE20
        end
    end
endmodule

// *** design/homing_sequencer.sv ***
// Homing search sequencer with Wishbone register access
`timescale 1ns/1ps
// Operation
// RULE1 - Current-position trigger, zero offset loads zero
// RULE2 - Nonzero offset: select 0 offset, 1 sum
// RULE3 - Completion clears trigger; rewrite 6 then re-enable
// RULE4 - Method setting accepts numbers 0 through 34
// RULE5 - M0 low, negative side: forward, back, creep
// RULE6 - M0 switch high: reverse until fall, creep
// RULE7 - M0 low, positive side: limit reverses, creep
// RULE8 - M1 low, negative side: limit, forward, creep
// RULE9 - M1 switch high: forward until fall, creep
// RULE10 - M1 low, positive side: rise reverses, creep
// RULE11 - M2 forward low, stop at index rise
// RULE12 - M2/M3 index present: latch origin, no move
// RULE13 - M2 limit reverses, index fall, forward creep
// RULE14 - M3 reverse low, stop at index rise
// RULE15 - M3 limit reverses, index fall, reverse creep
// RULE16 - M4 low: forward fast, then index creep
// RULE17 - M4 switch high: reverse, forward, index creep
// RULE18 - M4 positive side: limit, back, forward, creep
// RULE19 - Active during search; done after offset move
// RULE20 - Over time limit aborts with timeout fault
// RULE21 - Synchronise inputs; direction and speed per step
module homing_sequencer
    import homing_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES,
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic drive_enable,
    input wire logic home_switch,
    input wire logic pos_limit,
    input wire logic neg_limit,
    input wire logic index_pulse,
    input wire logic [POS_W-1:0] cur_pos,
    input wire logic offset_move_done,
    output logic move_run,
    output logic move_dir,
    output logic move_fast,
    output logic pos_load,
    output logic [POS_W-1:0] pos_load_value,
    output logic offset_move_req,
    output logic [POS_W-1:0] offset_move_dist,
    output logic [POS_W-1:0] origin_pos,
    output logic homing_active_out,
    output logic homing_done_out,
    output logic homing_timeout_fault
);
    // Byte-lane merge for register writes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Speed request for a given step
    function automatic logic fast_of(input seq_state_t st, input logic index_meth);
        return (st == ST_APPROACH) || (st == ST_RETURN) || (st == ST_BACK && !index_meth);
    endfunction

    // Motion present in a given step
    function automatic logic runs_in(input seq_state_t st);
        return (st == ST_APPROACH) || (st == ST_BACK) || (st == ST_RETURN) ||
               (st == ST_CREEP);
    endfunction

    sense_if sense ();
    seq_state_t state;
    seq_state_t next_state;
    logic [3:0] homing_trigger_select;
    logic [5:0] homing_method_select;
    logic [POS_W-1:0] home_offset_value;
    logic home_offset_select;
    logic [15:0] time_limit;
    logic bad_method;
    logic enable_prev;
    logic timer_expired;
    logic found;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Sensor conditioning
    sensor_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .raw({index_pulse, neg_limit, pos_limit, home_switch}),
        .sense(sense)
    );

    // Homing time limit
    homing_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .run(state != ST_IDLE),
        .limit_ms(time_limit),
        .expired(timer_expired)
    );

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // Lands at the acked edge
    wire [4:0] word_adr = {wb_adr_i[4:2], 2'b00};
    wire wr_trigger = bus_wr && (word_adr == OFS_TRIGGER);
    wire wr_method = bus_wr && (word_adr == OFS_METHOD);
    wire wr_offset = bus_wr && (word_adr == OFS_OFFSET);
    wire wr_offset_sel = bus_wr && (word_adr == OFS_OFFSET_SEL);
    wire wr_time = bus_wr && (word_adr == OFS_TIME_LIMIT);
    wire wr_status = bus_wr && (word_adr == OFS_STATUS);
    wire [31:0] wr_word = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [31:0] trig_word = merge_bytes({28'h0, homing_trigger_select}, wb_dat_i, wb_sel_i);
    wire [31:0] meth_word = merge_bytes({26'h0, homing_method_select}, wb_dat_i, wb_sel_i);
    wire [31:0] ofs_word = merge_bytes(home_offset_value, wb_dat_i, wb_sel_i);
    wire [31:0] time_word = merge_bytes({16'h0, time_limit}, wb_dat_i, wb_sel_i);
    wire [31:0] status_word = {25'h0, state, bad_method, homing_timeout_fault,
                               homing_done_out, homing_active_out};

    // Read selection; unmapped words read zero
    wire [31:0] rd_data =
        (word_adr == OFS_TRIGGER) ? {28'h0, homing_trigger_select} :
        (word_adr == OFS_METHOD) ? {26'h0, homing_method_select} :
        (word_adr == OFS_OFFSET) ? home_offset_value :
        (word_adr == OFS_OFFSET_SEL) ? {31'h0, home_offset_select} :
        (word_adr == OFS_TIME_LIMIT) ? {16'h0, time_limit} :
        (word_adr == OFS_STATUS) ? status_word : 32'h0000_0000;

    // Method decoding
    wire toward = (homing_method_select != METH_HOME_REV) &&
                  (homing_method_select != METH_INDEX_REV);
    wire is_index = (homing_method_select == METH_INDEX_FWD) ||
                    (homing_method_select == METH_INDEX_REV);
    wire is_hz = (homing_method_select == METH_HOME_INDEX);
    wire method_ok = (homing_method_select <= METH_HOME_INDEX);

    // Event decoding
    wire start_evt = drive_enable && !enable_prev && (state == ST_IDLE);
    wire start_search = start_evt && (homing_trigger_select == TRIG_IMMEDIATE);
    wire start_cur = start_evt && (homing_trigger_select == TRIG_CURRENT);
    wire home_rise = sense.rise[SNS_HOME];
    wire far_rise = toward ? sense.rise[SNS_POS] : sense.rise[SNS_NEG];
    wire target_rise = (is_index || is_hz) ? sense.rise[SNS_INDEX] : home_rise;
    wire back_exit = is_index ? sense.fall[SNS_INDEX] : sense.fall[SNS_HOME];
    wire abort = (state != ST_IDLE) && (!drive_enable || timer_expired);
    wire finish = (state == ST_OFFSET) && offset_move_done && !abort;
    wire next_dir = (next_state == ST_BACK) ? ~toward : toward;
    wire [POS_W-1:0] cur_load = (home_offset_value == '0) ? '0 : // RULE1
        (home_offset_select ? cur_pos + home_offset_value : home_offset_value); // RULE2

    // Search sequence
    always_comb begin
        next_state = state;
        found = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (start_search && method_ok) begin
                    if (is_index) begin
                        if (sense.level[SNS_INDEX]) begin
                            found = 1'b1; // RULE12
                        end else begin
                            next_state = ST_CREEP; // RULE11 RULE14
                        end
                    end else if (sense.level[SNS_HOME]) begin
                        next_state = ST_BACK; // RULE6 RULE9 RULE17
                    end else begin
                        next_state = ST_APPROACH; // RULE5 RULE8 RULE16
                    end
                end
            end
            ST_APPROACH: begin
                if (home_rise) begin
                    next_state = is_hz ? ST_CREEP : ST_BACK; // RULE5 RULE10 RULE16
                end else if (far_rise) begin
                    next_state = ST_BACK; // RULE7 RULE8 RULE18
                end
            end
            ST_BACK: begin
                if (back_exit) begin
                    next_state = is_hz ? ST_RETURN : ST_CREEP; // RULE13 RULE15 RULE17
                end
            end
            ST_RETURN: begin
                if (home_rise) begin
                    next_state = ST_CREEP; // RULE17 RULE18
                end
            end
            ST_CREEP: begin
                if (target_rise) begin
                    found = 1'b1; // RULE11 RULE14 RULE16
                end else if (is_index && far_rise) begin
                    next_state = ST_BACK; // RULE13 RULE15
                end
            end
            ST_OFFSET: begin
                if (offset_move_done) begin
                    next_state = ST_IDLE; // RULE19
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (found) begin
            next_state = ST_OFFSET;
        end
        if (abort) begin
            next_state = ST_IDLE; // RULE20
        end
    end

    // Bus answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // Settings registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            homing_method_select <= RST_METHOD;
            home_offset_value <= '0;
            home_offset_select <= 1'b0;
            time_limit <= RST_TIME_LIMIT;
        end else begin
            if (wr_method) begin
                homing_method_select <= meth_word[5:0]; // RULE4
            end
            if (wr_offset) begin
                home_offset_value <= ofs_word[POS_W-1:0];
            end
            if (wr_offset_sel) begin
                home_offset_select <= wr_word[0];
            end
            if (wr_time) begin
                time_limit <= time_word[15:0];
            end
        end
    end

    // Trigger setting; a software write wins over the completion clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            homing_trigger_select <= RST_TRIGGER;
        end else if (wr_trigger) begin
            homing_trigger_select <= trig_word[3:0];
        end else if (start_cur || finish) begin
            homing_trigger_select <= RST_TRIGGER; // RULE3
        end
    end

    // Sequencer state and motion requests
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            enable_prev <= 1'b0;
            move_run <= 1'b0;
            move_dir <= 1'b0;
            move_fast <= 1'b0;
        end else begin
            state <= next_state;
            enable_prev <= drive_enable;
            move_run <= runs_in(next_state); // RULE21
            move_dir <= next_dir; // RULE21
            move_fast <= fast_of(next_state, is_index); // RULE21
        end
    end

    // Origin latch, offset move and position load
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            origin_pos <= '0;
            offset_move_req <= 1'b0;
            pos_load <= 1'b0;
            pos_load_value <= '0;
        end else begin
            offset_move_req <= found && !abort;
            pos_load <= start_cur; // RULE1
            if (found) begin
                origin_pos <= cur_pos; // RULE12
            end
            if (start_cur) begin
                pos_load_value <= cur_load; // RULE2
            end
        end
    end

    // Status flags; the timeout fault is cleared by writing one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            homing_active_out <= 1'b0;
            homing_done_out <= 1'b0;
            homing_timeout_fault <= 1'b0;
            bad_method <= 1'b0;
        end else begin
            homing_active_out <= (next_state != ST_IDLE); // RULE19
            if (finish || start_cur) begin
                homing_done_out <= 1'b1; // RULE19
            end else if (start_search) begin
                homing_done_out <= 1'b0;
            end
            if (abort && timer_expired) begin
                homing_timeout_fault <= 1'b1; // RULE20
            end else if (wr_status && wr_word[STS_FAULT]) begin
                homing_timeout_fault <= 1'b0;
            end
            if (start_search) begin
                bad_method <= !method_ok;
            end
        end
    end

    assign offset_move_dist = home_offset_value;

    chk_zero_offset_load: assert property ( // RULE1
        start_cur && home_offset_value == '0 |=> pos_load && pos_load_value == '0)
        else $error("zero offset did not load zero");
    chk_offset_select_load: assert property ( // RULE2
        start_cur && home_offset_value != '0 |=> pos_load_value ==
            ($past(home_offset_select) ? $past(cur_pos) + $past(home_offset_value)
                                       : $past(home_offset_value)))
        else $error("offset load value wrong");
    chk_trigger_clear: assert property ( // RULE3
        start_cur && !wr_trigger |=> homing_trigger_select == RST_TRIGGER)
        else $error("trigger not cleared after completion");
    chk_method_store: assert property ( // RULE4
        wr_method && wb_sel_i[0] |=> homing_method_select == $past(wb_dat_i[5:0]))
        else $error("method write not stored");
    chk_home_rise_back: assert property ( // RULE5
        state == ST_APPROACH && home_rise && !is_hz && !abort
            |=> state == ST_BACK && move_dir == !toward && move_fast)
        else $error("home rise did not reverse fast");
    chk_back_to_creep: assert property ( // RULE6
        state == ST_BACK && back_exit && !is_hz && !abort
            |=> state == ST_CREEP && move_run && !move_fast && move_dir == toward)
        else $error("fall did not start low speed creep");
    chk_index_at_start: assert property ( // RULE12
        start_search && method_ok && is_index && sense.level[SNS_INDEX] && drive_enable
            |=> state == ST_OFFSET && !move_run ##0 origin_pos == $past(cur_pos))
        else $error("index present did not latch origin");
    chk_creep_stop: assert property ( // RULE11
        state == ST_CREEP && target_rise && !abort
            |=> !move_run && offset_move_req ##1 !offset_move_req)
        else $error("creep did not stop on target");
    chk_done_clears_active: assert property ( // RULE19
        finish |=> homing_done_out && !homing_active_out)
        else $error("done without active cleared");
    chk_timeout_abort: assert property ( // RULE20
        state != ST_IDLE && timer_expired |=> homing_timeout_fault && !homing_active_out
            ##1 !move_run)
        else $error("timeout did not abort");
    chk_hz_return: assert property ( // RULE17
        state == ST_BACK && is_hz && back_exit && !abort
            |=> state == ST_RETURN && move_dir && move_fast)
        else $error("index method did not return fast");
endmodule

// *** testbench/axis_model.sv ***
// Behavioural axis with switches, index marks and offset move
`timescale 1ns/1ps
module axis_model (
    input wire logic clk,
    input wire logic set_en,
    input wire logic [31:0] set_pos,
    input wire logic move_run,
    input wire logic move_dir,
    input wire logic move_fast,
    input wire logic offset_move_req,
    output logic home_switch,
    output logic pos_limit,
    output logic neg_limit,
    output logic index_pulse,
    output logic offset_move_done,
    output logic [31:0] cur_pos
);
    int pos = 0;
    int wait_n = 0;
    // Step the axis at the requested speed and direction
    always @(posedge clk) begin
        if (set_en) begin
            pos <= set_pos;
        end else if (move_run) begin
            pos <= pos + (move_dir ? 1 : -1) * (move_fast ? 4 : 1);
        end
    end
    // Sensor geometry along the axis
    assign home_switch = pos >= 205 && pos < 265;
    assign pos_limit = pos >= 900;
    assign neg_limit = pos <= 20;
    assign index_pulse = (pos % 100) >= 70 && (pos % 100) < 80;
    assign cur_pos = pos;
    // Offset move ends after a random delay of one to eight cycles
    always @(posedge clk) begin
        if (offset_move_req) begin
            wait_n <= 1 + $urandom % 8;
        end else if (wait_n != 0) begin
            wait_n <= wait_n - 1;
        end
    end
    assign offset_move_done = wait_n == 1;
endmodule

// *** testbench/homing_sequencer_tb.sv ***
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
module homing_sequencer_tb;
    import homing_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, drive_enable = 1'b0, set_en = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, set_pos = 32'h0;
    logic [31:0] wb_dat_o, cur_pos, pos_load_value, offset_move_dist, origin_pos;
    logic wb_ack_o, home_switch, pos_limit, neg_limit, index_pulse, offset_move_done;
    logic move_run, move_dir, move_fast, pos_load, offset_move_req;
    logic homing_active_out, homing_done_out, homing_timeout_fault;
    logic [31:0] q_rd[$], q_org[$], q_ld[$], q_dist[$];
    logic [1:0] dir_code = 2'h0;
    int err_total = 0;
    int comparisons = 0;
    int m_t[14] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 4, 4, 4};
    int st[14] = '{100, 230, 500, 100, 230, 500, 150, 175, 880, 190, 60, 100, 230, 500};
    logic [3:0] ex[14] = '{4'h5, 4'h5, 4'h5, 4'hA, 4'hA, 4'hA, 4'h7, 4'h3, 4'h7, 4'hB, 4'hB,
        4'h7, 4'h7, 4'h7};
    always #10 clk = ~clk;
    homing_sequencer #(.TICK_CYCLES(4)) dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .drive_enable, .home_switch,
        .pos_limit, .neg_limit, .index_pulse, .cur_pos, .offset_move_done, .move_run,
        .move_dir, .move_fast, .pos_load, .pos_load_value, .offset_move_req, .offset_move_dist,
        .origin_pos, .homing_active_out, .homing_done_out, .homing_timeout_fault);
    axis_model sim_axis (.clk, .set_en, .set_pos, .move_run, .move_dir, .move_fast,
        .offset_move_req, .home_switch, .pos_limit, .neg_limit, .index_pulse,
        .offset_move_done, .cur_pos);
    // Comparison with mismatch report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] g);
        cmp(g, q_rd.size() ? q_rd.pop_front() : ~g);
    endtask
    task automatic cmp_org(input logic [31:0] g);
        cmp(g, q_org.size() ? q_org.pop_front() : ~g);
    endtask
    task automatic cmp_ld(input logic [31:0] g);
        cmp(g, q_ld.size() ? q_ld.pop_front() : ~g);
    endtask
    task automatic cmp_dist(input logic [31:0] g);
        cmp(g, q_dist.size() ? q_dist.pop_front() : ~g);
    endtask
    // Origin class from where the search stopped
    function automatic logic [1:0] zone(input logic [31:0] o);
        if (o >= 205 && o < 217) return 2'h1;
        if (o >= 253 && o < 265) return 2'h2;
        if (o % 100 >= 70 && o % 100 < 80) return 2'h3;
        return 2'h0;
    endfunction
    // Watch outputs and take the oldest note per result
    always @(posedge clk) begin
        if (!drive_enable) dir_code <= 2'h0;
        else if (move_run) dir_code <= move_dir ? 2'h1 : 2'h2;
        if (wb_ack_o && !wb_we_i) cmp_rd(wb_dat_o);
        if (offset_move_req) cmp_org({28'h0, dir_code, zone(origin_pos)});
        if (offset_move_req) cmp_dist(offset_move_dist);
        if (pos_load) cmp_ld(pos_load_value);
    end
    // Classic single Wishbone cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) err_total++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Place the axis, set up a run and raise enable
    task automatic start(input int m, input int p);
        drive_enable <= 1'b0;
        set_pos <= p;
        set_en <= 1'b1;
        @(posedge clk);
        set_en <= 1'b0;
        bus(1'b1, OFS_METHOD, m);
        bus(1'b1, OFS_TRIGGER, {28'h0, TRIG_IMMEDIATE});
        repeat (4) @(posedge clk);
        drive_enable <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic settle(input bit f);
        int n;
        n = 0;
        cmp({31'h0, homing_active_out}, 32'h1);
        while ((f ? homing_timeout_fault : homing_done_out) !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        cmp({31'h0, n < 3000}, 32'h1);
    endtask
    task automatic results();
        err_total += q_rd.size() + q_org.size() + q_ld.size() + q_dist.size();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        r = $urandom(501);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFS_TIME_LIMIT, 32'h0000_2710);
        rd(5'h18, 32'h0);
        bus(1'b1, OFS_METHOD, 32'h22);
        rd(OFS_METHOD, 32'h22);
        start(5, 300);
        repeat (10) @(posedge clk);
        rd(OFS_STATUS, 32'h8);
        r = ($urandom & 32'h0FFF_FFFF) | 32'h1;
        for (int i = 0; i < 3; i++) begin
            drive_enable <= 1'b0;
            bus(1'b1, OFS_OFFSET, i ? r : 32'h0);
            bus(1'b1, OFS_OFFSET_SEL, i == 1 ? 32'h0 : 32'h1);
            bus(1'b1, OFS_TRIGGER, {28'h0, TRIG_CURRENT});
            q_ld.push_back(i == 0 ? 32'h0 : i == 1 ? r : 32'd300 + r);
            repeat (4) @(posedge clk);
            drive_enable <= 1'b1;
            repeat (4) @(posedge clk);
            rd(OFS_TRIGGER, 32'h0);
        end
        for (int i = 0; i < 14; i++) begin
            q_org.push_back({28'h0, ex[i]});
            q_dist.push_back(r);
            start(m_t[i], st[i]);
            settle(1'b0);
            rd(OFS_STATUS, 32'h2);
            rd(OFS_TRIGGER, 32'h0);
        end
        bus(1'b1, OFS_TIME_LIMIT, 32'h5);
        start(0, 100);
        settle(1'b1);
        rd(OFS_STATUS, 32'h4);
        bus(1'b1, OFS_STATUS, 32'h4);
        rd(OFS_STATUS, 32'h0);
        repeat (4) @(posedge clk);
        results();
    end
endmodule
